/* hw/tpg_pkg.sv */
// constants and carrier types of the test pattern generator and checker
package tpg_pkg;
	localparam int WORD_W = 256;
	localparam int DW_PER_WORD = 8;
	localparam int LEN_W = 32;
	localparam int CNT_W = 36;
	localparam int ADDR_W = 48;
	localparam int INC_W = 52;
	localparam int BUF_W = 256;
	localparam int BUF_DEPTH = 16;
	localparam int BLK_SHIFT = 4;
	localparam logic [3:0] LAST_WORD_IDX = 4'hf;
	localparam logic [3:0] WORD_IDX_RST = 4'h0;
	localparam logic [CNT_W-1:0] CNT_RST = 36'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 36'h1;
	localparam logic [ADDR_W-1:0] ADDR_RST = 48'h0;
	localparam logic [ADDR_W-1:0] ADDR_ONE = 48'h1;
	localparam logic [INC_W-1:0] INC_RST = 52'h0;
	localparam logic [INC_W-1:0] INC_STEP = 52'h8;
	localparam logic [31:0] LFSR_RST = 32'h0000_0001;
	localparam logic [WORD_W-1:0] WORD_ZERO = {WORD_W{1'b0}};
	localparam logic [WORD_W-1:0] WORD_ONES = {WORD_W{1'b1}};

	typedef enum logic [2:0] {PAT_ZERO, PAT_ONE, PAT_INC, PAT_DEC, PAT_LFSR} tpg_pat_e;

	typedef struct packed {
		logic [LEN_W-1:0] total_length;
		logic [ADDR_W-1:0] start_block_addr;
		tpg_pat_e pattern_select;
		logic verify_en;
	} tpg_cfg_s;
endpackage

/* hw/tpg_top.sv */
// test pattern generator and checker with its write-path buffer
`timescale 1ns/1ps

module tpg_buf #(
	parameter int WIDTH = 256,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// filling side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// draining side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic do_wr;
	logic do_rd;

	// full when pointers differ only in the wrap bit
	assign in_ready_o = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
	assign out_valid_o = (wr_ptr != rd_ptr);
	assign out_data_o = mem[rd_ptr[AW-1:0]];
	assign do_wr = in_valid_i && in_ready_o;
	assign do_rd = out_valid_o && out_ready_i;

	// storage array
	always_ff @(posedge clk_i)
	begin
		if (do_wr)
			mem[wr_ptr[AW-1:0]] <= in_data_i;
	end

	// pointers
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			if (do_wr)
				wr_ptr <= wr_ptr + 1'b1;
			if (do_rd)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule

module tpg_top (
	// clock and reset
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	// configuration and command starts
	input wire tpg_pkg::tpg_cfg_s CFG_I,
	input wire logic WRITE_START_I,
	input wire logic READ_START_I,
	// write-side FIFO
	input wire logic WFIFO_ALMOST_FULL_I,
	output logic WFIFO_PUSH_O,
	output logic [tpg_pkg::WORD_W-1:0] WFIFO_PUSH_WORD_O,
	// read-side FIFO
	input wire logic RFIFO_IS_EMPTY_I,
	output logic RFIFO_POP_O,
	input wire logic [tpg_pkg::WORD_W-1:0] RFIFO_POP_WORD_I,
	// status
	output logic WRITE_BUSY_O,
	output logic READ_BUSY_O,
	output logic COMPARE_FAIL_O
);
	import tpg_pkg::*;
	logic write_active_q;
	logic read_active_q;
	logic wfifo_push_q;
	logic [WORD_W-1:0] wfifo_push_word_q;
	logic rfifo_pop_q;
	logic check_q;
	logic compare_fail;
	logic [CNT_W-1:0] moved_count;
	logic [CNT_W-1:0] gen_count;
	logic [CNT_W-1:0] end_size_q;
	logic [ADDR_W-1:0] block_addr_cnt;
	logic [3:0] word_idx;
	logic [INC_W-1:0] inc_cnt;
	logic [31:0] lfsr_a;
	logic [31:0] lfsr_b;
	logic [31:0] seed_a;
	logic [31:0] seed_b;
	logic [31:0] cur_a;
	logic [31:0] cur_b;
	logic [31:0] step_a [4];
	logic [31:0] step_b [4];
	logic [WORD_W-1:0] pat_word;
	logic any_start;
	logic gen_push;
	logic gen_adv;
	logic buf_in_ready;
	logic buf_out_valid;
	logic buf_out_ready;
	logic [WORD_W-1:0] buf_out_data;
	logic done_w;
	logic done_r;
	logic mismatch;

	// one LFSR step of x^31 + x^21 + x + 1
	function automatic logic [31:0] lfsr_step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	assign any_start = WRITE_START_I || READ_START_I;
	// last transfer of a command, seen while its strobe is high
	assign done_w = wfifo_push_q && ((moved_count + CNT_ONE) == end_size_q);
	assign done_r = rfifo_pop_q && ((moved_count + CNT_ONE) == end_size_q);

	// command starts and transfer-active flags
	always_ff @(posedge SYS_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			write_active_q <= 1'b0;
			read_active_q <= 1'b0;
			end_size_q <= CNT_RST;
		end
		else
		begin
			if (any_start)
				end_size_q <= {CFG_I.total_length, BLK_SHIFT'(0)};
			if (WRITE_START_I)
				write_active_q <= 1'b1;
			else if (done_w || (end_size_q == CNT_RST))
				write_active_q <= 1'b0;
			if (READ_START_I)
				read_active_q <= 1'b1;
			else if (done_r || (end_size_q == CNT_RST))
				read_active_q <= 1'b0;
		end
	end

	// generator feeds the buffer until the whole size is produced
	assign gen_push = write_active_q && buf_in_ready && (gen_count != end_size_q);
	assign gen_adv = gen_push || check_q;
	assign buf_out_ready = write_active_q && !WFIFO_ALMOST_FULL_I && !done_w;

	tpg_buf #(
		.WIDTH(BUF_W),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.clk_i(SYS_CLK_I),
		.rst_i(RST_I),
		.in_valid_i(gen_push),
		.in_ready_o(buf_in_ready),
		.in_data_i(pat_word),
		.out_valid_o(buf_out_valid),
		.out_ready_i(buf_out_ready),
		.out_data_o(buf_out_data)
	);

	// registered push toward the write-side FIFO
	always_ff @(posedge SYS_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			wfifo_push_q <= 1'b0;
			wfifo_push_word_q <= WORD_ZERO;
		end
		else
		begin
			wfifo_push_q <= buf_out_valid && buf_out_ready;
			if (buf_out_valid && buf_out_ready)
				wfifo_push_word_q <= buf_out_data;
		end
	end

	// read pops while data is present; word arrives one cycle later
	always_ff @(posedge SYS_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			rfifo_pop_q <= 1'b0;
			check_q <= 1'b0;
		end
		else
		begin
			rfifo_pop_q <= read_active_q && !RFIFO_IS_EMPTY_I && !done_r;
			check_q <= rfifo_pop_q;
		end
	end

	// moved-data and generated-data counters
	always_ff @(posedge SYS_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			moved_count <= CNT_RST;
			gen_count <= CNT_RST;
		end
		else if (any_start)
		begin
			moved_count <= CNT_RST;
			gen_count <= CNT_RST;
		end
		else
		begin
			if (wfifo_push_q || rfifo_pop_q)
				moved_count <= moved_count + CNT_ONE;
			if (gen_push)
				gen_count <= gen_count + CNT_ONE;
		end
	end

	// block address, word index and sequence counters
	always_ff @(posedge SYS_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			block_addr_cnt <= ADDR_RST;
			word_idx <= WORD_IDX_RST;
			inc_cnt <= INC_RST;
			lfsr_a <= LFSR_RST;
			lfsr_b <= LFSR_RST;
		end
		else if (any_start)
		begin
			block_addr_cnt <= CFG_I.start_block_addr;
			word_idx <= WORD_IDX_RST;
			inc_cnt <= INC_RST;
		end
		else if (gen_adv)
		begin
			word_idx <= word_idx + 4'h1;
			if (word_idx == LAST_WORD_IDX)
				block_addr_cnt <= block_addr_cnt + ADDR_ONE;
			inc_cnt <= inc_cnt + INC_STEP;
			lfsr_a <= step_a[3];
			lfsr_b <= step_b[3];
		end
	end

	// seeds mix the block address with its inverse; reload each block
	assign seed_a = {block_addr_cnt[15:0], ~block_addr_cnt[31:16]};
	assign seed_b = {~block_addr_cnt[15:0], block_addr_cnt[31:16]};
	assign cur_a = (word_idx == WORD_IDX_RST) ? seed_a : lfsr_a;
	assign cur_b = (word_idx == WORD_IDX_RST) ? seed_b : lfsr_b;

	// look-ahead: four LFSR steps per half in one clock
	always_comb
	begin
		step_a[0] = lfsr_step(cur_a);
		step_b[0] = lfsr_step(cur_b);
		for (int k = 1; k < 4; k++)
		begin
			step_a[k] = lfsr_step(step_a[k-1]);
			step_b[k] = lfsr_step(step_b[k-1]);
		end
	end

	// dword lanes of the current pattern word
	for (genvar i = 0; i < DW_PER_WORD; i++)
	begin : g_dw
		logic [31:0] inc_dw;
		logic [31:0] lfsr_dw;
		assign inc_dw = inc_cnt[31:0] + 32'(i);
		assign lfsr_dw = (i < 4) ? step_a[i % 4] : step_b[i % 4];
		always_comb
		begin
			if ((i < 2) && (word_idx == WORD_IDX_RST) && (CFG_I.pattern_select > PAT_ONE))
				pat_word[i*32 +: 32] = (i == 0) ? block_addr_cnt[31:0] :
					{16'h0, block_addr_cnt[47:32]};
			else
			begin
				case (CFG_I.pattern_select)
					PAT_ZERO: pat_word[i*32 +: 32] = 32'h0;
					PAT_ONE: pat_word[i*32 +: 32] = 32'hffff_ffff;
					PAT_INC: pat_word[i*32 +: 32] = inc_dw;
					PAT_DEC: pat_word[i*32 +: 32] = ~inc_dw;
					PAT_LFSR: pat_word[i*32 +: 32] = lfsr_dw;
					default: pat_word[i*32 +: 32] = 32'h0;
				endcase
			end
		end
	end

	// the read word is judged against the same generated pattern
	assign mismatch = check_q && (RFIFO_POP_WORD_I != pat_word);

	// sticky fail flag; a mismatch wins over the start clear
	always_ff @(posedge SYS_CLK_I or posedge RST_I)
	begin
		if (RST_I)
			compare_fail <= 1'b0;
		else if (mismatch && CFG_I.verify_en)
			compare_fail <= 1'b1;
		else if (any_start)
			compare_fail <= 1'b0;
	end

	// outputs from flops
	assign WFIFO_PUSH_O = wfifo_push_q;
	assign WFIFO_PUSH_WORD_O = wfifo_push_word_q;
	assign RFIFO_POP_O = rfifo_pop_q;
	assign WRITE_BUSY_O = write_active_q;
	assign READ_BUSY_O = read_active_q;
	assign COMPARE_FAIL_O = compare_fail;

	// checks on the write path
	a_push_needs_room: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		wfifo_push_q |-> $past(write_active_q) && !$past(WFIFO_ALMOST_FULL_I))
		else $error("push without active flag or with almost-full");
	a_start_sets_active: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		WRITE_START_I |=> write_active_q)
		else $error("write start did not raise active flag");
	a_push_counts: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		wfifo_push_q && !any_start |=> moved_count == $past(moved_count) + CNT_ONE)
		else $error("push did not advance moved count");
	a_end_stops_write: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		done_w && !WRITE_START_I |=> !wfifo_push_q && !write_active_q)
		else $error("write did not stop at end size");
	// checks on the read path, the block address, the fail flag and the zero pattern
	a_pop_follows_data: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		read_active_q && !RFIFO_IS_EMPTY_I && !done_r |=> rfifo_pop_q ##1 check_q)
		else $error("pop or check missing while data present");
	a_end_stops_read: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		done_r && !READ_START_I |=> !rfifo_pop_q && !read_active_q)
		else $error("read did not stop at end size");
	a_addr_steps: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		gen_adv && !any_start && word_idx == LAST_WORD_IDX
		|=> block_addr_cnt == $past(block_addr_cnt) + ADDR_ONE)
		else $error("block address did not step after block");
	a_fail_on_miss: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		mismatch && CFG_I.verify_en |=> compare_fail)
		else $error("mismatch did not set fail");
	a_fail_needs_verify: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		$rose(compare_fail) |-> $past(CFG_I.verify_en) && $past(check_q))
		else $error("fail set without verify enable");
	a_zero_pattern: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		CFG_I.pattern_select == PAT_ZERO |-> pat_word == WORD_ZERO)
		else $error("zero pattern not constant");
endmodule

/* test/tpg_far_model.sv */
// behavioural model of the write-side and read-side FIFOs around the generator
`timescale 1ns/1ps
module tpg_far_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// write-side FIFO
	input wire logic stall_i,
	input wire logic push_i,
	input wire logic [tpg_pkg::WORD_W-1:0] push_word_i,
	output logic almost_full_o,
	// read-side FIFO
	input wire logic pop_i,
	output logic is_empty_o,
	output logic [tpg_pkg::WORD_W-1:0] pop_word_o
);
	import tpg_pkg::*;
	logic [WORD_W-1:0] wq[$];
	logic [WORD_W-1:0] rq[$];
	// a stall requested by the bench stands for a nearly full buffer
	assign almost_full_o = stall_i;
	// every push lands in the capture queue
	always @(posedge clk_i)
		if (!rst_i && push_i)
			wq.push_back(push_word_i);
	// a pop hands out the next word one cycle later; an idle bus is inverted
	always @(posedge clk_i or posedge rst_i)
		if (rst_i)
		begin
			is_empty_o <= 1'b1;
			pop_word_o <= '0;
		end
		else
		begin
			if (pop_i && rq.size() > 0)
				pop_word_o <= rq.pop_front();
			else
				pop_word_o <= ~pop_word_o;
			is_empty_o <= (rq.size() == 0);
		end
endmodule

/* test/tpg_top_tb_top.sv */
// self-checking bench of the pattern generator and checker
`timescale 1ns/1ps
module tpg_top_tb_top;
	import tpg_pkg::*;
	localparam time DLY = 2;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	tpg_cfg_s cfg = '0;
	logic wr_go = 1'b0;
	logic rd_go = 1'b0;
	logic stall = 1'b0;
	logic push, pop, af, empty, wbusy, rbusy, fail;
	logic [WORD_W-1:0] push_word, pop_word;
	logic [WORD_W-1:0] exq[$];
	int errors = 0;
	int checks = 0;
	// 40 MHz clock
	always #12.5 sys_clk = ~sys_clk;
	tpg_top DUT (.SYS_CLK_I(sys_clk), .RST_I(rst), .CFG_I(cfg), .WRITE_START_I(wr_go),
		.READ_START_I(rd_go), .WFIFO_ALMOST_FULL_I(af), .WFIFO_PUSH_O(push),
		.WFIFO_PUSH_WORD_O(push_word), .RFIFO_IS_EMPTY_I(empty), .RFIFO_POP_O(pop),
		.RFIFO_POP_WORD_I(pop_word), .WRITE_BUSY_O(wbusy), .READ_BUSY_O(rbusy),
		.COMPARE_FAIL_O(fail));
	tpg_far_model FAR (.clk_i(sys_clk), .rst_i(rst), .stall_i(stall), .push_i(push),
		.push_word_i(push_word), .almost_full_o(af), .pop_i(pop), .is_empty_o(empty),
		.pop_word_o(pop_word));
	// step past edges, then a small delay before driving
	task automatic tick(input int n = 1);
		repeat (n) @(posedge sys_clk);
		#DLY;
	endtask
	task automatic chk(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
		checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// wait for both commands to finish, bounded
	task automatic idle;
		int k;
		for (k = 0; k < 600 && (wbusy | rbusy) !== 1'b0; k++)
			tick();
		if (k == 600)
		begin
			errors++;
			print_verdict();
		end
	endtask
	function automatic logic [31:0] lf(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// expected word stream of one transfer
	task automatic gen(input tpg_pat_e p, input int n);
		logic [31:0] sa;
		logic [31:0] sb;
		logic [ADDR_W-1:0] a;
		logic [WORD_W-1:0] w;
		exq.delete();
		for (int k = 0; k < n; k++)
		begin
			a = cfg.start_block_addr + ADDR_W'(k / 16);
			if (k % 16 == 0)
			begin
				sa = {a[15:0], ~a[31:16]};
				sb = {~a[15:0], a[31:16]};
			end
			for (int i = 0; i < 4; i++)
			begin
				sa = lf(sa);
				sb = lf(sb);
				w[32*i +: 32] = sa;
				w[32*i+128 +: 32] = sb;
			end
			if (p != PAT_LFSR)
				for (int i = 0; i < 8; i++)
					w[32*i +: 32] = 32'(k * 8 + i);
			if (p == PAT_DEC)
				w = ~w;
			if (p == PAT_ZERO)
				w = WORD_ZERO;
			if (p == PAT_ONE)
				w = WORD_ONES;
			if (k % 16 == 0 && p >= PAT_INC)
				w[63:0] = {16'h0, a};
			exq.push_back(w);
		end
	endtask
	// write one transfer, optionally pausing it, and compare the pushed stream
	task automatic run_write(input tpg_pat_e p, input int blocks, input bit hold);
		int n;
		n = blocks * 16;
		cfg.pattern_select = p;
		cfg.total_length = 32'(blocks);
		gen(p, n);
		FAR.wq.delete();
		wr_go = 1'b1;
		tick();
		wr_go = 1'b0;
		tick();
		chk(WORD_W'(wbusy), WORD_W'(1));
		chk(WORD_W'(pop), WORD_ZERO);
		if (hold)
		begin
			tick(4);
			stall = 1'b1;
			for (int i = 0; i < 6; i++)
			begin
				tick();
				chk(WORD_W'(push), WORD_ZERO);
			end
			stall = 1'b0;
		end
		idle();
		tick();
		chk(WORD_W'(FAR.wq.size()), WORD_W'(n));
		for (int i = 0; i < n; i++)
			chk(FAR.wq[i], exq[i]);
	endtask
	// read one transfer, optionally corrupting one word, and judge the flag
	task automatic run_read(input tpg_pat_e p, input int blocks, input int bad,
		input logic ven, input logic fexp);
		cfg.pattern_select = p;
		cfg.total_length = 32'(blocks);
		cfg.verify_en = ven;
		gen(p, blocks * 16);
		FAR.rq = exq;
		if (bad >= 0)
			FAR.rq[bad] = ~FAR.rq[bad];
		rd_go = 1'b1;
		tick();
		rd_go = 1'b0;
		tick();
		chk(WORD_W'({rbusy, pop}), WORD_W'(2'b11));
		idle();
		tick(3);
		chk(WORD_W'(fail), WORD_W'(fexp));
		chk(WORD_W'(FAR.rq.size()), WORD_ZERO);
	endtask
	// main sequence
	initial
	begin
		cfg.verify_en = 1'b1;
		cfg.start_block_addr = 48'h0012_ffff_ffff;
		tick(5);
		chk(WORD_W'({push, pop, wbusy, rbusy, fail}), WORD_ZERO);
		tick(5);
		rst = 1'b0;
		tick();
		for (int i = 0; i < 5; i++)
			run_write(tpg_pat_e'(i), 2, i == 2);
		for (int i = 0; i < 5; i++)
			run_read(tpg_pat_e'(i), 2, -1, 1'b1, 1'b0);
		run_read(PAT_DEC, 1, 5, 1'b0, 1'b0);
		run_read(PAT_INC, 2, 20, 1'b1, 1'b1);
		run_read(PAT_LFSR, 2, 31, 1'b1, 1'b1);
		run_read(PAT_ZERO, 1, -1, 1'b1, 1'b0);
		print_verdict();
	end
endmodule
